// >>> safe_stop_pkg.sv
// Constants, field layout and state codes of the safe stop sequencer
// Operation
// - Torque off outranks every other function
// - Torque off aborts a running controlled stop
// - Stop-then-off beats stop-and-hold
// - Controlled stop honours stopping time and mode
// - Monitoring runs alongside stops, equal priority
// - Bus control bits start a normal stop
// - Emergency bit runs configured torque off or stop
// - Internal error starts an error stop
// - Two separate restart settings, off and hold
// - Emergency restart follows the torque-off setting
// - Acknowledged mode waits for restart acknowledge
// - After error, fault acknowledge before restart
// - Automatic restart only from a stopped state
// - Torque off blocks PWM to power stage
// - Torque off clears status word bit 15
// - Torque off from bus, error or emergency
// - Torque off sequence has no parameters
// - Raw bus torque-off bit readable, unaltered
// - Source select 0 disables bus, 1 enables
// - Restart setting 0 acknowledged, 1 automatic
// - Settings writable only via safety parameter list
package safe_stop_pkg;
  localparam int unsigned CLK_HZ = 10_000_000;
  localparam int unsigned MS_PER_S = 1000;
  // Printed indices; byte address is four times the index
  localparam logic [15:0] IDX_TO_VIEW = 16'h2875;
  localparam logic [15:0] IDX_TO_SRC = 16'h2891;
  localparam logic [15:0] IDX_TO_RESTART = 16'h2892;
  localparam logic [15:0] IDX_STOP_TIME = 16'h2894;
  localparam logic [15:0] IDX_SS1_MODE = 16'h2897;
  localparam logic [15:0] IDX_HOLD_RESTART = 16'h289F;
  localparam logic [15:0] IDX_EMG_FUNC = 16'h28A0;
  localparam logic [15:0] IDX_STATUS = 16'h28F0;
  localparam logic [15:0] IDX_ACK_CMD = 16'h28F1;
  // Synchronised pin vector layout
  localparam int unsigned IN_W = 8;
  localparam int unsigned IN_TO = 0;
  localparam int unsigned IN_OFF = 1;
  localparam int unsigned IN_HOLD = 2;
  localparam int unsigned IN_EMG = 3;
  localparam int unsigned IN_RACK = 4;
  localparam int unsigned IN_FACK = 5;
  localparam int unsigned IN_ERR = 6;
  localparam int unsigned IN_STILL = 7;
  // Ack command and status fields
  localparam int unsigned ACK_RESTART = 0;
  localparam int unsigned ACK_FAULT = 1;
  localparam int unsigned STAT_ERR = 5;
  localparam int unsigned STAT_PWM = 6;
  localparam int unsigned STAT_B15 = 7;
  // Reset values of the safety settings
  localparam logic RST_SRC = 1'h1;
  localparam logic RST_RESTART = 1'h0;
  localparam logic RST_SS1_MODE = 1'h0;
  localparam logic RST_EMG_FUNC = 1'h0;
  localparam logic [15:0] RST_STOP_TIME = 16'h0064;
  // Emergency function, stop mode, restart and source encodings
  localparam logic EMG_TORQUE_OFF = 1'h0;
  localparam logic MODE_AT_STILL = 1'h1;
  localparam logic RESTART_AUTO = 1'h1;
  localparam logic SRC_ACTIVE = 1'h1;
  typedef enum logic [4:0] {
    ST_RUN = 5'h01,
    ST_STOP_OFF = 5'h02,
    ST_STOP_HOLD = 5'h04,
    ST_HOLD = 5'h08,
    ST_OFF = 5'h10
  } stop_state_t;
endpackage

// >>> sync_if.sv
// Pin vector carried to and from the input synchroniser
`timescale 1ns/10ps
interface sync_if #(parameter int unsigned W = 8);
  logic [W-1:0] raw;
  logic [W-1:0] synced;
  modport sync (input raw, output synced);
  modport user (output raw, input synced);
endinterface

// >>> input_sync.sv
// Two-stage synchroniser bank for the asynchronous pins
`timescale 1ns/10ps
module input_sync #(
  parameter int unsigned W = 8
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  sync_if.sync port
);
  logic [W-1:0] meta_reg;
  logic [W-1:0] sync_reg;

  // First stage is read only by the second
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      meta_reg <= '0;
      sync_reg <= '0;
    end else begin
      meta_reg <= port.raw;
      sync_reg <= meta_reg;
    end
  end

  assign port.synced = sync_reg;
endmodule

// >>> safe_stop_sequencer.sv
// Stop priority, restart and PWM gating with AHB-Lite register access
//
// The AHB-Lite slave port was chosen for this implementation.
`timescale 1ns/10ps
module safe_stop_sequencer #(
  parameter int unsigned CYC_PER_MS = safe_stop_pkg::CLK_HZ / safe_stop_pkg::MS_PER_S
) (
  input wire logic sys_clk,
  input wire logic arst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic bus_torque_off,
  input wire logic bus_stop_off,
  input wire logic bus_stop_hold,
  input wire logic bus_emergency,
  input wire logic bus_restart_ack,
  input wire logic bus_fault_ack,
  input wire logic internal_error,
  input wire logic standstill,
  input wire logic sp_wr_en,
  input wire logic [15:0] sp_wr_index,
  input wire logic [15:0] sp_wr_data,
  output logic pwm_enable,
  output logic status_b15,
  output logic torque_off_active,
  output logic hold_active
);
  function automatic logic idx_hit(input logic [15:0] a, input logic [15:0] idx);
    idx_hit = (a == idx);
  endfunction

  sync_if #(.W(safe_stop_pkg::IN_W)) sif ();

  input_sync #(.W(safe_stop_pkg::IN_W)) u_sync (
    .sys_clk(sys_clk),
    .arst_n(arst_n),
    .port(sif.sync)
  );

  assign sif.raw = {standstill, internal_error, bus_fault_ack, bus_restart_ack,
                    bus_emergency, bus_stop_hold, bus_stop_off, bus_torque_off};

  wire logic in_to = sif.synced[safe_stop_pkg::IN_TO];
  wire logic in_off = sif.synced[safe_stop_pkg::IN_OFF];
  wire logic in_hold = sif.synced[safe_stop_pkg::IN_HOLD];
  wire logic in_emg = sif.synced[safe_stop_pkg::IN_EMG];
  wire logic in_rack = sif.synced[safe_stop_pkg::IN_RACK];
  wire logic in_fack = sif.synced[safe_stop_pkg::IN_FACK];
  wire logic in_err = sif.synced[safe_stop_pkg::IN_ERR];
  // Standstill monitor is read only while stopping, in ST_STOP_OFF and ST_STOP_HOLD
  wire logic in_still = sif.synced[safe_stop_pkg::IN_STILL];

  // Safety settings, loaded only from the parameter list port
  logic src_sel_reg;
  logic restart_off_reg;
  logic restart_hold_reg;
  logic ss1_mode_reg;
  logic emg_func_reg;
  logic [15:0] stop_time_reg;

  wire logic sp_src = sp_wr_en & idx_hit(sp_wr_index, safe_stop_pkg::IDX_TO_SRC);
  wire logic sp_roff = sp_wr_en & idx_hit(sp_wr_index, safe_stop_pkg::IDX_TO_RESTART);
  wire logic sp_rhold = sp_wr_en & idx_hit(sp_wr_index, safe_stop_pkg::IDX_HOLD_RESTART);
  wire logic sp_mode = sp_wr_en & idx_hit(sp_wr_index, safe_stop_pkg::IDX_SS1_MODE);
  wire logic sp_emg = sp_wr_en & idx_hit(sp_wr_index, safe_stop_pkg::IDX_EMG_FUNC);
  wire logic sp_time = sp_wr_en & idx_hit(sp_wr_index, safe_stop_pkg::IDX_STOP_TIME);

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      src_sel_reg <= safe_stop_pkg::RST_SRC;
      restart_off_reg <= safe_stop_pkg::RST_RESTART;
      restart_hold_reg <= safe_stop_pkg::RST_RESTART;
      ss1_mode_reg <= safe_stop_pkg::RST_SS1_MODE;
      emg_func_reg <= safe_stop_pkg::RST_EMG_FUNC;
      stop_time_reg <= safe_stop_pkg::RST_STOP_TIME;
    end else begin
      if (sp_src) src_sel_reg <= sp_wr_data[0];
      if (sp_roff) restart_off_reg <= sp_wr_data[0];
      if (sp_rhold) restart_hold_reg <= sp_wr_data[0];
      if (sp_mode) ss1_mode_reg <= sp_wr_data[0];
      if (sp_emg) emg_func_reg <= sp_wr_data[0];
      if (sp_time) stop_time_reg <= sp_wr_data;
    end
  end

  // AHB-Lite slave, zero wait states, always OKAY
  logic wr_pend_reg;
  logic [15:0] wr_idx_reg;
  logic [31:0] hrdata_reg;
  logic hreadyout_reg;
  logic hresp_reg;
  wire logic ahb_acc = hsel & htrans[1] & hready;
  wire logic [15:0] a_idx = haddr[17:2];
  wire logic ack_wr = wr_pend_reg & idx_hit(wr_idx_reg, safe_stop_pkg::IDX_ACK_CMD);
  wire logic sw_rack = ack_wr & hwdata[safe_stop_pkg::ACK_RESTART];
  wire logic sw_fack = ack_wr & hwdata[safe_stop_pkg::ACK_FAULT];

  // Sequencer state
  safe_stop_pkg::stop_state_t state_reg;
  safe_stop_pkg::stop_state_t state_next;
  logic err_pending_reg;
  logic rack_prev_reg;
  logic fack_prev_reg;
  logic [31:0] pre_reg;
  logic [15:0] ms_cnt_reg;
  logic pwm_reg;
  logic b15_reg;
  logic off_act_reg;
  logic hold_act_reg;

  wire logic [7:0] status_byte = {b15_reg, pwm_reg, err_pending_reg, state_reg};
  wire logic [31:0] rd_next =
    idx_hit(a_idx, safe_stop_pkg::IDX_TO_VIEW) ? {31'h0000_0000, in_to} :
    idx_hit(a_idx, safe_stop_pkg::IDX_TO_SRC) ? {31'h0000_0000, src_sel_reg} :
    idx_hit(a_idx, safe_stop_pkg::IDX_TO_RESTART) ? {31'h0000_0000, restart_off_reg} :
    idx_hit(a_idx, safe_stop_pkg::IDX_HOLD_RESTART) ? {31'h0000_0000, restart_hold_reg} :
    idx_hit(a_idx, safe_stop_pkg::IDX_SS1_MODE) ? {31'h0000_0000, ss1_mode_reg} :
    idx_hit(a_idx, safe_stop_pkg::IDX_EMG_FUNC) ? {31'h0000_0000, emg_func_reg} :
    idx_hit(a_idx, safe_stop_pkg::IDX_STOP_TIME) ? {16'h0000, stop_time_reg} :
    idx_hit(a_idx, safe_stop_pkg::IDX_STATUS) ? {24'h00_0000, status_byte} :
    32'h0000_0000;

  // Settings have no write path here; bus writes only reach the ack command
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wr_pend_reg <= 1'h0;
      wr_idx_reg <= 16'h0000;
      hrdata_reg <= 32'h0000_0000;
      hreadyout_reg <= 1'h1;
      hresp_reg <= 1'h0;
    end else begin
      wr_pend_reg <= ahb_acc & hwrite;
      wr_idx_reg <= a_idx;
      if (ahb_acc && !hwrite) hrdata_reg <= rd_next;
    end
  end

  assign hrdata = hrdata_reg;
  assign hreadyout = hreadyout_reg;
  assign hresp = hresp_reg;

  // Acknowledge edges from the bus, plus software pulses
  wire logic rack_p = (in_rack & ~rack_prev_reg) | sw_rack;
  wire logic fack_p = (in_fack & ~fack_prev_reg) | sw_fack;

  // Request sources
  wire logic bus_off = in_to & (src_sel_reg == safe_stop_pkg::SRC_ACTIVE);
  wire logic emg_off = in_emg & (emg_func_reg == safe_stop_pkg::EMG_TORQUE_OFF);
  wire logic emg_stop = in_emg & (emg_func_reg != safe_stop_pkg::EMG_TORQUE_OFF);
  // Error stop drives a fixed torque off, nothing configurable
  wire logic off_req = bus_off | err_pending_reg | emg_off;
  wire logic soff_req = in_off | emg_stop;
  wire logic hold_req = in_hold;
  wire logic any_stop = off_req | soff_req | hold_req;

  // Restart qualification; ack is void while a fault is pending
  wire logic rack_ok = rack_p & ~err_pending_reg;
  // Emergency stops end in torque off, so they share this setting
  wire logic restart_off_ok = (restart_off_reg == safe_stop_pkg::RESTART_AUTO) | rack_ok;
  wire logic restart_hold_ok = (restart_hold_reg == safe_stop_pkg::RESTART_AUTO) | rack_ok;

  // Stopping time in whole milliseconds
  wire logic stopping = (state_reg == safe_stop_pkg::ST_STOP_OFF) | (state_reg == safe_stop_pkg::ST_STOP_HOLD);
  wire logic timer_clr = ~stopping | (state_next != state_reg);
  wire logic ms_tick = (pre_reg == CYC_PER_MS - 1);
  wire logic time_up = (ms_cnt_reg >= stop_time_reg);
  wire logic off_done = time_up | ((ss1_mode_reg == safe_stop_pkg::MODE_AT_STILL) & in_still);
  wire logic hold_done = time_up | in_still;

  always_comb begin
    state_next = state_reg;
    if (off_req) begin
      // Aborts any controlled stop in progress
      state_next = safe_stop_pkg::ST_OFF;
    end else begin
      unique case (state_reg)
        safe_stop_pkg::ST_RUN: begin
          if (soff_req) begin
            state_next = safe_stop_pkg::ST_STOP_OFF;
          end else if (hold_req) begin
            state_next = safe_stop_pkg::ST_STOP_HOLD;
          end
        end
        safe_stop_pkg::ST_STOP_OFF: begin
          if (off_done) state_next = safe_stop_pkg::ST_OFF;
        end
        safe_stop_pkg::ST_STOP_HOLD: begin
          if (soff_req) begin
            state_next = safe_stop_pkg::ST_STOP_OFF;
          end else if (hold_done) begin
            state_next = safe_stop_pkg::ST_HOLD;
          end
        end
        safe_stop_pkg::ST_HOLD: begin
          if (soff_req) begin
            state_next = safe_stop_pkg::ST_STOP_OFF;
          end else if (!hold_req && restart_hold_ok) begin
            state_next = safe_stop_pkg::ST_RUN;
          end
        end
        safe_stop_pkg::ST_OFF: begin
          if (!any_stop && restart_off_ok) state_next = safe_stop_pkg::ST_RUN;
        end
        default: state_next = safe_stop_pkg::ST_OFF;
      endcase
    end
  end

  // One decision per clock; outputs register alongside the state
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= safe_stop_pkg::ST_OFF;
      pwm_reg <= 1'h0;
      b15_reg <= 1'h0;
      off_act_reg <= 1'h1;
      hold_act_reg <= 1'h0;
    end else begin
      state_reg <= state_next;
      pwm_reg <= (state_next != safe_stop_pkg::ST_OFF);
      b15_reg <= (state_next != safe_stop_pkg::ST_OFF);
      off_act_reg <= (state_next == safe_stop_pkg::ST_OFF);
      hold_act_reg <= (state_next == safe_stop_pkg::ST_HOLD);
    end
  end

  // Set wins over fault acknowledge; active error cannot be cleared
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      err_pending_reg <= 1'h0;
      rack_prev_reg <= 1'h0;
      fack_prev_reg <= 1'h0;
    end else begin
      rack_prev_reg <= in_rack;
      fack_prev_reg <= in_fack;
      if (in_err) begin
        err_pending_reg <= 1'h1;
      end else if (fack_p) begin
        err_pending_reg <= 1'h0;
      end
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      pre_reg <= 32'h0000_0000;
      ms_cnt_reg <= 16'h0000;
    end else if (timer_clr) begin
      pre_reg <= 32'h0000_0000;
      ms_cnt_reg <= 16'h0000;
    end else if (ms_tick) begin
      pre_reg <= 32'h0000_0000;
      // Saturates so a long stop never wraps back to early
      if (!time_up) ms_cnt_reg <= ms_cnt_reg + 16'h0001;
    end else begin
      pre_reg <= pre_reg + 32'h0000_0001;
    end
  end

  assign pwm_enable = pwm_reg;
  assign status_b15 = b15_reg;
  assign torque_off_active = off_act_reg;
  assign hold_active = hold_act_reg;

  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (!arst_n);

  sequence s_off_released;
    state_reg == safe_stop_pkg::ST_OFF && restart_off_reg && !any_stop;
  endsequence

  sequence s_back_running;
    state_reg == safe_stop_pkg::ST_RUN && pwm_reg;
  endsequence

  sequence s_error_seen;
    $rose(in_err) ##1 err_pending_reg;
  endsequence

  a_off_first: assert property (off_req |=> state_reg == safe_stop_pkg::ST_OFF)
    else $error("torque off request not taken");
  a_stop_abort: assert property (
    (state_reg == safe_stop_pkg::ST_STOP_OFF && off_req) |=> (state_reg == safe_stop_pkg::ST_OFF && !pwm_reg))
    else $error("controlled stop not aborted");
  a_off_over_hold: assert property (
    (state_reg == safe_stop_pkg::ST_RUN && soff_req && hold_req && !off_req)
    |=> state_reg == safe_stop_pkg::ST_STOP_OFF)
    else $error("hold stop chosen over off stop");
  a_stop_time_kept: assert property (
    (state_reg == safe_stop_pkg::ST_STOP_OFF && !off_req && !off_done)
    |=> state_reg == safe_stop_pkg::ST_STOP_OFF)
    else $error("controlled stop ended early");
  a_error_stop: assert property (s_error_seen |=> state_reg == safe_stop_pkg::ST_OFF)
    else $error("error stop not entered");
  a_ack_wait: assert property (
    (state_reg == safe_stop_pkg::ST_OFF && !restart_off_reg && !rack_ok) |=> state_reg == safe_stop_pkg::ST_OFF)
    else $error("restart without acknowledge");
  a_fault_first: assert property (
    (state_reg == safe_stop_pkg::ST_OFF && err_pending_reg) |=> !pwm_reg)
    else $error("restart before fault acknowledge");
  a_auto_restart: assert property (s_off_released |=> s_back_running)
    else $error("automatic restart missing");
  a_pwm_block: assert property (state_reg == safe_stop_pkg::ST_OFF |-> !pwm_reg && off_act_reg)
    else $error("pwm not blocked in torque off");
  a_status_bit: assert property (off_act_reg |-> !b15_reg)
    else $error("status bit 15 set in torque off");
  a_bus_no_write: assert property (
    (wr_pend_reg && wr_idx_reg == safe_stop_pkg::IDX_TO_SRC && !sp_src) |=> $stable(src_sel_reg))
    else $error("bus write changed a safety setting");
  a_emg_stop_sel: assert property (
    (state_reg == safe_stop_pkg::ST_RUN && emg_stop && !off_req) |=> state_reg == safe_stop_pkg::ST_STOP_OFF)
    else $error("emergency stop function not applied");
  a_emg_off: assert property (
    (in_emg && emg_func_reg == safe_stop_pkg::EMG_TORQUE_OFF) |=> state_reg == safe_stop_pkg::ST_OFF && !pwm_reg)
    else $error("emergency torque off not taken");
  a_err_latch: assert property (in_err |=> err_pending_reg)
    else $error("internal error not latched");
  a_fack_clear: assert property ((err_pending_reg && fack_p && !in_err) |=> !err_pending_reg)
    else $error("fault acknowledge did not clear the error");
  a_hold_monitor: assert property (
    (state_reg == safe_stop_pkg::ST_STOP_HOLD && in_still && !off_req && !soff_req)
    |=> state_reg == safe_stop_pkg::ST_HOLD && hold_act_reg)
    else $error("standstill not seen during hold stop");
  a_hold_ack_wait: assert property (
    (state_reg == safe_stop_pkg::ST_HOLD && !restart_hold_reg && !rack_ok && !any_stop)
    |=> state_reg == safe_stop_pkg::ST_HOLD)
    else $error("hold left without acknowledge");
  a_hold_auto: assert property (
    (state_reg == safe_stop_pkg::ST_HOLD && restart_hold_reg && !any_stop)
    |=> state_reg == safe_stop_pkg::ST_RUN && pwm_reg)
    else $error("automatic restart from hold missing");
  a_still_mode: assert property (
    (state_reg == safe_stop_pkg::ST_STOP_OFF && ss1_mode_reg == safe_stop_pkg::MODE_AT_STILL && in_still)
    |=> state_reg == safe_stop_pkg::ST_OFF)
    else $error("standstill mode did not end the stop");
  a_src_disabled: assert property (
    (state_reg == safe_stop_pkg::ST_RUN && in_to && src_sel_reg != safe_stop_pkg::SRC_ACTIVE && !in_emg
     && !in_off && !in_hold && !err_pending_reg) |=> state_reg == safe_stop_pkg::ST_RUN)
    else $error("disabled bus source stopped the drive");
  a_view_raw: assert property (
    (ahb_acc && !hwrite && a_idx == safe_stop_pkg::IDX_TO_VIEW) |=> hrdata_reg == {31'h0000_0000, $past(in_to)})
    else $error("torque off view not the raw bit");
endmodule

// >>> bus_master_model.sv
// Safety bus master and power stage model
`timescale 1ns/10ps
module bus_master_model (
  input wire logic sys_clk,
  input wire logic pwm_enable,
  output logic bus_torque_off,
  output logic bus_stop_off,
  output logic bus_stop_hold,
  output logic bus_emergency,
  output logic bus_restart_ack,
  output logic bus_fault_ack,
  output logic moving
);
  logic confirmed = 1'b0;
  initial begin
    {bus_emergency, bus_stop_hold, bus_stop_off, bus_torque_off} = 4'h0;
    bus_restart_ack = 1'b0;
    bus_fault_ack = 1'b0;
  end
  // Power stage moves only with pwm passed and a confirmation given
  assign moving = pwm_enable & confirmed;
  // Order is emergency, hold, off, torque off; a new request withdraws confirmation
  task set_req(input logic [3:0] r);
    @(posedge sys_clk);
    {bus_emergency, bus_stop_hold, bus_stop_off, bus_torque_off} <= r;
    confirmed <= 1'b0;
  endtask
  // Held three cycles so the synchroniser sees one clean rising edge
  task ack(input logic fault);
    @(posedge sys_clk);
    if (fault) begin
      bus_fault_ack <= 1'b1;
    end else begin
      bus_restart_ack <= 1'b1;
    end
    repeat (3) @(posedge sys_clk);
    bus_fault_ack <= 1'b0;
    bus_restart_ack <= 1'b0;
    repeat (3) @(posedge sys_clk);
  endtask
  task confirm;
    @(posedge sys_clk);
    confirmed <= 1'b1;
  endtask
endmodule

// >>> safe_stop_sequencer_tb.sv
// Self-checking bench for the safe stop sequencer
`timescale 1ns/10ps
module safe_stop_sequencer_tb;
  logic sys_clk = 1'b0;
  logic arst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0000_0000;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0000_0000;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic hreadyout, hresp, hready;
  logic b_to, b_off, b_hold, b_emg, b_rack, b_fack, moving;
  logic internal_error = 1'b0;
  logic standstill = 1'b0;
  logic sp_wr_en = 1'b0;
  logic [15:0] sp_wr_index = 16'h0000;
  logic [15:0] sp_wr_data = 16'h0000;
  logic pwm_enable, status_b15, torque_off_active, hold_active;
  int fail_count = 0;
  int samples_checked = 0;
  assign hready = hreadyout;
  always #50 sys_clk = ~sys_clk;
  // Short ms so the stop timer runs in tens of cycles
  safe_stop_sequencer #(.CYC_PER_MS(4)) dut (.sys_clk(sys_clk), .arst_n(arst_n), .hsel(hsel), .haddr(haddr),
    .htrans(htrans), .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .bus_torque_off(b_to), .bus_stop_off(b_off), .bus_stop_hold(b_hold),
    .bus_emergency(b_emg), .bus_restart_ack(b_rack), .bus_fault_ack(b_fack), .internal_error(internal_error),
    .standstill(standstill), .sp_wr_en(sp_wr_en), .sp_wr_index(sp_wr_index), .sp_wr_data(sp_wr_data),
    .pwm_enable(pwm_enable), .status_b15(status_b15), .torque_off_active(torque_off_active),
    .hold_active(hold_active));
  bus_master_model pm (.sys_clk(sys_clk), .pwm_enable(pwm_enable), .bus_torque_off(b_to), .bus_stop_off(b_off),
    .bus_stop_hold(b_hold), .bus_emergency(b_emg), .bus_restart_ack(b_rack), .bus_fault_ack(b_fack),
    .moving(moving));
  task final_report;
    $display("Mismatches %0d, comparisons %0d", fail_count, samples_checked);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task check(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      fail_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task wait_rdy;
    int n;
    n = 0;
    @(posedge sys_clk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 20) begin
        fail_count++;
        final_report;
      end
      @(posedge sys_clk);
    end
  endtask
  task ahb(input logic w, input logic [15:0] idx, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {14'h0000, idx, 2'h0};
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
  endtask
  task rd_chk(input logic [15:0] idx, input logic [31:0] exp);
    ahb(1'b0, idx, 32'h0000_0000);
    check(rd, exp);
    check({31'h0000_0000, hresp}, 32'h0000_0000);
  endtask
  task sp_wr(input logic [15:0] idx, input logic [15:0] d);
    @(posedge sys_clk);
    sp_wr_en <= 1'b1;
    sp_wr_index <= idx;
    sp_wr_data <= d;
    @(posedge sys_clk);
    sp_wr_en <= 1'b0;
  endtask
  // Expected pwm, b15, torque off, hold
  task out_chk(input int n, input logic [3:0] exp);
    repeat (n) @(posedge sys_clk);
    #1;
    check({28'h000_0000, pwm_enable, status_b15, torque_off_active, hold_active}, {28'h000_0000, exp});
  endtask
  initial begin
    repeat (60000) @(posedge sys_clk);
    fail_count++;
    final_report;
  end
  initial begin
    repeat (4) @(posedge sys_clk);
    arst_n <= 1'b1;
    out_chk(1, 4'b0010);
    rd_chk(safe_stop_pkg::IDX_TO_SRC, 32'h0000_0001);
    rd_chk(safe_stop_pkg::IDX_STATUS, 32'h0000_0010);
    rd_chk(16'h2880, 32'h0000_0000);
    ahb(1'b1, safe_stop_pkg::IDX_TO_RESTART, 32'h0000_0001);
    rd_chk(safe_stop_pkg::IDX_TO_RESTART, 32'h0000_0000);
    ahb(1'b1, safe_stop_pkg::IDX_TO_SRC, 32'hFFFF_FFFE);
    rd_chk(safe_stop_pkg::IDX_TO_SRC, 32'h0000_0001);
    pm.ack(1'b0);
    out_chk(3, 4'b1100);
    rd_chk(safe_stop_pkg::IDX_STATUS, 32'h0000_00C1);
    pm.set_req(4'h1);
    out_chk(4, 4'b0010);
    rd_chk(safe_stop_pkg::IDX_TO_VIEW, 32'h0000_0001);
    pm.ack(1'b0);
    out_chk(2, 4'b0010);
    pm.set_req(4'h0);
    out_chk(4, 4'b0010);
    pm.ack(1'b0);
    out_chk(3, 4'b1100);
    sp_wr(safe_stop_pkg::IDX_STOP_TIME, 16'h0005);
    rd_chk(safe_stop_pkg::IDX_STOP_TIME, 32'h0000_0005);
    pm.set_req(4'h2);
    out_chk(8, 4'b1100);
    pm.set_req(4'h3);
    out_chk(4, 4'b0010);
    pm.set_req(4'h0);
    pm.ack(1'b0);
    pm.set_req(4'h2);
    out_chk(16, 4'b1100);
    out_chk(12, 4'b0010);
    pm.set_req(4'h0);
    pm.ack(1'b0);
    pm.set_req(4'h6);
    out_chk(4, 4'b1100);
    rd_chk(safe_stop_pkg::IDX_STATUS, 32'h0000_00C2);
    out_chk(24, 4'b0010);
    pm.set_req(4'h0);
    pm.ack(1'b0);
    // Automatic restart for torque off; the hold setting stays on acknowledge
    sp_wr(safe_stop_pkg::IDX_TO_RESTART, 16'h0001);
    pm.set_req(4'h1);
    out_chk(4, 4'b0010);
    pm.set_req(4'h0);
    out_chk(4, 4'b1100);
    check({31'h0000_0000, moving}, 32'h0000_0000);
    pm.confirm;
    #1 check({31'h0000_0000, moving}, 32'h0000_0001);
    pm.set_req(4'h8);
    out_chk(4, 4'b0010);
    pm.set_req(4'h0);
    out_chk(4, 4'b1100);
    sp_wr(safe_stop_pkg::IDX_EMG_FUNC, 16'h0001);
    pm.set_req(4'h8);
    out_chk(4, 4'b1100);
    rd_chk(safe_stop_pkg::IDX_STATUS, 32'h0000_00C2);
    out_chk(24, 4'b0010);
    pm.set_req(4'h0);
    out_chk(4, 4'b1100);
    @(posedge sys_clk) standstill <= 1'b1;
    pm.set_req(4'h4);
    out_chk(5, 4'b1101);
    pm.set_req(4'h0);
    out_chk(4, 4'b1101);
    pm.ack(1'b0);
    out_chk(3, 4'b1100);
    sp_wr(safe_stop_pkg::IDX_SS1_MODE, 16'h0001);
    pm.set_req(4'h2);
    out_chk(5, 4'b0010);
    pm.set_req(4'h0);
    out_chk(4, 4'b1100);
    sp_wr(safe_stop_pkg::IDX_HOLD_RESTART, 16'h0001);
    pm.set_req(4'h4);
    out_chk(5, 4'b1101);
    pm.set_req(4'h0);
    out_chk(4, 4'b1100);
    @(posedge sys_clk) standstill <= 1'b0;
    sp_wr(safe_stop_pkg::IDX_TO_RESTART, 16'h0000);
    internal_error <= 1'b1;
    out_chk(4, 4'b0010);
    @(posedge sys_clk) internal_error <= 1'b0;
    rd_chk(safe_stop_pkg::IDX_STATUS, 32'h0000_0030);
    pm.ack(1'b0);
    out_chk(2, 4'b0010);
    pm.ack(1'b1);
    pm.ack(1'b0);
    out_chk(3, 4'b1100);
    sp_wr(safe_stop_pkg::IDX_TO_SRC, 16'h0000);
    pm.set_req(4'h1);
    out_chk(4, 4'b1100);
    rd_chk(safe_stop_pkg::IDX_TO_VIEW, 32'h0000_0001);
    pm.set_req(4'h0);
    // Software acknowledges through the command word
    @(posedge sys_clk) internal_error <= 1'b1;
    out_chk(4, 4'b0010);
    @(posedge sys_clk) internal_error <= 1'b0;
    ahb(1'b1, safe_stop_pkg::IDX_ACK_CMD, 32'hFFFF_FFFD);
    out_chk(2, 4'b0010);
    ahb(1'b1, safe_stop_pkg::IDX_ACK_CMD, 32'h0000_0002);
    ahb(1'b1, safe_stop_pkg::IDX_ACK_CMD, 32'h0000_0001);
    out_chk(2, 4'b1100);
    final_report;
  end
endmodule
